// *** smbus_client_pkg.sv ***
// Constants, timing counts and state codes of the two-wire client port.
// Assumes a 20 MHz system clock and a pulled-up, open-drain bus.

`default_nettype none

package smbus_client_pkg;

  localparam logic [6:0]  CLIENT_ADDR     = 7'h28;
  localparam logic [7:0]  PTR_RESET       = 8'h00;
  localparam logic [7:0]  PTR_STEP        = 8'h01;
  localparam logic [2:0]  LAST_BIT        = 3'h7;

  localparam longint      CLK_HZ          = 20_000_000;
  localparam longint      LOW_TIMEOUT_MS  = 30;
  localparam longint      IDLE_TIMEOUT_US = 200;
  // Longest wait rounds down; least idle time rounds up.
  localparam longint      LOW_TIMEOUT_CYC =
    (CLK_HZ * LOW_TIMEOUT_MS) / 1000;
  localparam longint      IDLE_CYC_L      =
    (CLK_HZ * IDLE_TIMEOUT_US + 999_999) / 1_000_000;
  localparam logic [12:0] IDLE_CYC        = IDLE_CYC_L[12:0];

  typedef enum logic [2:0]
  {
    ST_IDLE     = 3'b000,
    ST_ADDR     = 3'b001,
    ST_ADDR_ACK = 3'b010,
    ST_RX       = 3'b011,
    ST_RX_ACK   = 3'b100,
    ST_TX       = 3'b101,
    ST_TX_ACK   = 3'b110,
    ST_IGNORE   = 3'b111
  } client_state_e;

endpackage

`default_nettype wire

// *** pin_sync.sv ***
// Three-stage synchroniser with agreement filter for one bus pin.
// Assumes the pin is asynchronous to clk_i; output idles at RESET_VAL.

`default_nettype none

module pin_sync
#(
  parameter logic RESET_VAL = 1'b1
)
(
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Pin and filtered level
  input  wire logic pin_i,
  output var  logic level_o
);

  logic stage1;
  logic stage2;
  logic stage3;

  // The first stage feeds only the second, so metastability stays contained.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      stage1 <= RESET_VAL;
      stage2 <= RESET_VAL;
      stage3 <= RESET_VAL;
    end
    else
    begin
      stage1 <= pin_i;
      stage2 <= stage1;
      stage3 <= stage2;
    end
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      level_o <= RESET_VAL;
    else if (stage2 == stage3)
      level_o <= stage3;
  end

endmodule

`default_nettype wire

// *** smbus_client.sv ***
// Two-wire target port: start, stop, address match, byte transfers and the
// register pointer, plus optional clock-low and idle timeouts.
// Assumes the register map answers reg_rdata_i for reg_addr_o within one
// clock, and that the bus lines are open drain with external pull-ups.

`default_nettype none

module smbus_client
  import smbus_client_pkg::*;
#(
  parameter int unsigned TIMEOUT_CYCLES = int'(LOW_TIMEOUT_CYC)
)
(
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Bus pins
  input  wire logic       bus_clock_pin_i,
  input  wire logic       bus_data_pin_i,
  output var  logic       bus_data_pin_o,
  output var  logic       bus_data_pin_oe_o,
  // Configuration
  input  wire logic       timeout_en_i,
  input  wire logic       lowest_power_sleep_bit_i,
  // Register map side
  output var  logic [7:0] reg_addr_o,
  output var  logic [7:0] reg_wdata_o,
  output var  logic       reg_we_o,
  output var  logic       reg_rd_o,
  input  wire logic [7:0] reg_rdata_i,
  // Status
  output var  logic       awake_o,
  output var  logic       busy_o
);

  import smbus_client_pkg::*;

  logic          scl_s;
  logic          sda_s;
  logic          scl_q;
  logic          sda_q;
  logic          scl_rise;
  logic          scl_fall;
  logic          start_ev;
  logic          stop_ev;
  logic          timeout_ev;
  logic          to_en;
  logic [19:0]   low_cnt;
  logic [12:0]   idle_cnt;
  client_state_e state;
  logic [2:0]    bit_cnt;
  logic          byte_full;
  logic [7:0]    rx_sh;
  logic [7:0]    tx_sh;
  logic          read_dir;
  logic          first_byte;
  logic          host_ack;
  logic          rx_done;
  logic          tx_done;
  logic          tx_load;
  logic [7:0]    ptr;

  // The address compare is shared by the sequencer and the acknowledge drive.
  function automatic logic own_addr(input logic [7:0] b);
    return b[7:1] == CLIENT_ADDR;
  endfunction

  // Oversampling at 20 MHz leaves ample margin even at 400 kHz.
  pin_sync #(.RESET_VAL(1'b1)) u_scl_sync
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (bus_clock_pin_i),
    .level_o (scl_s)
  );

  pin_sync #(.RESET_VAL(1'b1)) u_sda_sync
  (
    .clk_i   (clk_i),
    .rst_i   (rst_i),
    .pin_i   (bus_data_pin_i),
    .level_o (sda_s)
  );

  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      scl_q <= 1'b1;
      sda_q <= 1'b1;
    end
    else
    begin
      scl_q <= scl_s;
      sda_q <= sda_s;
    end
  end

  assign scl_rise = scl_s & ~scl_q;
  assign scl_fall = ~scl_s & scl_q;
  assign start_ev = scl_s & scl_q & sda_q & ~sda_s;
  assign stop_ev  = scl_s & scl_q & ~sda_q & sda_s;

  // Enable is held low through reset so timeouts start disabled.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      to_en <= 1'b0;
    else
      to_en <= timeout_en_i;
  end

  // Counters saturate so a stuck bus fires the reset only once.
  always_ff @(posedge clk_i)
  begin
    if (rst_i || !to_en || scl_s)
      low_cnt <= 20'h00000;
    else if (low_cnt != 20'hfffff)
      low_cnt <= low_cnt + 20'h00001;
  end

  always_ff @(posedge clk_i)
  begin
    if (rst_i || !to_en || !scl_s || !sda_s)
      idle_cnt <= 13'h0000;
    else if (idle_cnt != 13'h1fff)
      idle_cnt <= idle_cnt + 13'h0001;
  end

  assign timeout_ev = to_en && state != ST_IDLE &&
    ((low_cnt == 20'(TIMEOUT_CYCLES)) ||
     (idle_cnt == IDLE_CYC + 13'h0001));

  assign rx_done = scl_fall && byte_full && state == ST_RX;
  assign tx_done = scl_fall && state == ST_TX && bit_cnt == LAST_BIT;
  assign tx_load = scl_fall && !start_ev && !stop_ev && !timeout_ev &&
    ((state == ST_ADDR_ACK && read_dir) ||
     (state == ST_TX_ACK && host_ack));

  // Main protocol sequencer; start wins over every state, stop and timeouts
  // return to idle.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      state      <= ST_IDLE;
      bit_cnt    <= 3'h0;
      byte_full  <= 1'b0;
      rx_sh      <= 8'h00;
      tx_sh      <= 8'h00;
      read_dir   <= 1'b0;
      first_byte <= 1'b0;
      host_ack   <= 1'b0;
    end
    else if (start_ev)
    begin
      state     <= ST_ADDR;
      bit_cnt   <= 3'h0;
      byte_full <= 1'b0;
    end
    else if (stop_ev || timeout_ev)
    begin
      state     <= ST_IDLE;
      byte_full <= 1'b0;
    end
    else
    begin
      if (scl_rise && (state == ST_ADDR || state == ST_RX))
      begin
        rx_sh     <= {rx_sh[6:0], sda_s};
        bit_cnt   <= bit_cnt + 3'h1;
        byte_full <= (bit_cnt == LAST_BIT);
      end
      if (scl_rise && state == ST_TX_ACK)
        host_ack <= ~sda_s;
      if (scl_fall)
      begin
        unique case (state)
          ST_IDLE, ST_IGNORE:
            state <= state;
          ST_ADDR:
            if (byte_full)
            begin
              byte_full <= 1'b0;
              read_dir  <= rx_sh[0];
              if (own_addr(rx_sh))
                state <= ST_ADDR_ACK;
              else
                state <= ST_IGNORE;
            end
          ST_ADDR_ACK:
          begin
            bit_cnt    <= 3'h0;
            first_byte <= 1'b1;
            if (read_dir)
            begin
              tx_sh <= reg_rdata_i;
              state <= ST_TX;
            end
            else
              state <= ST_RX;
          end
          ST_RX:
            if (byte_full)
            begin
              byte_full <= 1'b0;
              state     <= ST_RX_ACK;
            end
          ST_RX_ACK:
          begin
            first_byte <= 1'b0;
            bit_cnt    <= 3'h0;
            state      <= ST_RX;
          end
          ST_TX:
            if (bit_cnt == LAST_BIT)
              state <= ST_TX_ACK;
            else
            begin
              bit_cnt <= bit_cnt + 3'h1;
              tx_sh   <= {tx_sh[6:0], 1'b0};
            end
          ST_TX_ACK:
            if (host_ack)
            begin
              bit_cnt <= 3'h0;
              tx_sh   <= reg_rdata_i;
              state   <= ST_TX;
            end
            else
              state <= ST_IGNORE;
        endcase
      end
    end
  end

  // Data line drive. The clock line is only ever an input here.
  always_ff @(posedge clk_i)
  begin
    bus_data_pin_o <= 1'b0;
    if (rst_i || start_ev || stop_ev || timeout_ev)
      bus_data_pin_oe_o <= 1'b0;
    else if (scl_fall)
    begin
      if ((state == ST_ADDR && byte_full && own_addr(rx_sh)) ||
          (state == ST_RX && byte_full))
        bus_data_pin_oe_o <= 1'b1;
      else if (tx_load)
        bus_data_pin_oe_o <= ~reg_rdata_i[7];
      else if (state == ST_TX && bit_cnt != LAST_BIT)
        bus_data_pin_oe_o <= ~tx_sh[6];
      else
        bus_data_pin_oe_o <= 1'b0;
    end
  end

  // Pointer survives stops and timeouts; only reset clears it.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
      ptr <= PTR_RESET;
    else if (!start_ev && !stop_ev && !timeout_ev)
    begin
      if (rx_done && first_byte)
        ptr <= rx_sh;
      else if (rx_done)
        ptr <= ptr + PTR_STEP;
      else if (tx_done)
        ptr <= ptr + PTR_STEP;
    end
  end

  // Write strobe carries the pointer value from before its increment.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      reg_we_o    <= 1'b0;
      reg_rd_o    <= 1'b0;
      reg_wdata_o <= 8'h00;
      reg_addr_o  <= PTR_RESET;
    end
    else
    begin
      reg_we_o   <= rx_done && !first_byte && !start_ev && !stop_ev &&
                    !timeout_ev;
      reg_rd_o   <= tx_load;
      reg_addr_o <= ptr;
      if (rx_done)
        reg_wdata_o <= rx_sh;
    end
  end

  // Sleep is never cleared here; the wake request just follows the
  // transfer. Pointer-only accesses in sleep behave as awake ones.
  always_ff @(posedge clk_i)
  begin
    if (rst_i)
    begin
      awake_o <= 1'b0;
      busy_o  <= 1'b0;
    end
    else
    begin
      awake_o <= lowest_power_sleep_bit_i && state != ST_IDLE &&
                 state != ST_IGNORE && state != ST_ADDR;
      busy_o  <= state != ST_IDLE;
    end
  end

endmodule

`default_nettype wire

// *** smbus_client_assertions.sv ***
// Checker of the smbus_client port behaviour, bound from the bench.
// Assumes host bit timing slow enough for the pin synchronisers.
`default_nettype none
module smbus_client_assertions
#(
  parameter int unsigned TIMEOUT_CYCLES = 200
)
(
  // Clock and reset
  input wire logic       clk_i,
  input wire logic       rst_i,
  // Watched ports
  input wire logic       bus_clock_pin_i,
  input wire logic       bus_data_pin_i,
  input wire logic       bus_data_pin_oe_o,
  input wire logic       timeout_en_i,
  input wire logic       lowest_power_sleep_bit_i,
  input wire logic [7:0] reg_addr_o,
  input wire logic       reg_we_o,
  input wire logic       awake_o,
  input wire logic       busy_o
);
  timeunit 1ns;
  timeprecision 1ns;
  logic [7:0]  wa;
  logic [19:0] n_low;
  logic [12:0] n_idle;
  always_ff @(posedge clk_i)
    if (reg_we_o)
      wa <= reg_addr_o;
  always_ff @(posedge clk_i)
    if (rst_i || !busy_o || !timeout_en_i || bus_clock_pin_i)
      n_low <= 20'h0;
    else
      n_low <= n_low + 20'h1;
  // Counts raw pin time, so the bounds allow for synchroniser lag.
  always_ff @(posedge clk_i)
    if (rst_i || !busy_o || !timeout_en_i || !bus_clock_pin_i
        || !bus_data_pin_i)
      n_idle <= 13'h0;
    else
      n_idle <= n_idle + 13'h1;
  default clocking cb @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  sequence s_hold;
    bus_data_pin_oe_o [*4];
  endsequence
  property p_we_pulse;
    reg_we_o |=> !reg_we_o;
  endproperty
  a_we_pulse: assert property (p_we_pulse) else $error("long store");
  property p_we_step;
    reg_we_o |=> ##[0:4] (reg_addr_o == wa + 8'h01);
  endproperty
  a_we_step: assert property (p_we_step) else $error("no step");
  property p_quiet;
    !busy_o [*2] |-> !bus_data_pin_oe_o;
  endproperty
  a_quiet: assert property (p_quiet) else $error("drive idle");
  property p_drive_low;
    $rose(bus_data_pin_oe_o) |-> !bus_clock_pin_i;
  endproperty
  a_drive_low: assert property (p_drive_low) else $error("clk hi");
  property p_ack_hold;
    $rose(bus_data_pin_oe_o) |-> s_hold;
  endproperty
  a_ack_hold: assert property (p_ack_hold) else $error("short ack");
  property p_low_to;
    n_low < TIMEOUT_CYCLES + 20;
  endproperty
  a_low_to: assert property (p_low_to) else $error("no low reset");
  property p_idle_to;
    n_idle < 13'hfb4;
  endproperty
  a_idle_to: assert property (p_idle_to) else $error("no idle");
  property p_awake;
    awake_o |-> lowest_power_sleep_bit_i && (busy_o || $past(busy_o));
  endproperty
  a_awake: assert property (p_awake) else $error("bad awake");
endmodule
`default_nettype wire

// *** smbus_host_model.sv ***
// Host model: bit-level master of the two-wire bus.
// Assumes pull-ups; the bench resolves the data wire.
`default_nettype none
module smbus_host_model
(
  // Resolved data line
  input  wire logic sda_i,
  // Driven lines
  output var  logic scl_o,
  output var  logic sda_low_o
);
  timeunit 1ns;
  timeprecision 1ns;
  // A long low phase leaves the client time to answer.
  int unsigned stretch = 300;
  initial
  begin
    scl_o = 1'b1;
    sda_low_o = 1'b0;
  end
  task automatic bit_io(input logic b, output logic s);
    #100 sda_low_o = !b;
    #(stretch) scl_o = 1'b1;
    #100 s = sda_i;
    #100 scl_o = 1'b0;
  endtask
  task automatic start();
    #100 sda_low_o = 1'b0;
    #(stretch) scl_o = 1'b1;
    #200 sda_low_o = 1'b1;
    #200 scl_o = 1'b0;
  endtask
  task automatic stop();
    #100 sda_low_o = 1'b1;
    #(stretch) scl_o = 1'b1;
    #200 sda_low_o = 1'b0;
    #200;
  endtask
  task automatic release_bus();
    #100 sda_low_o = 1'b0;
    #(stretch) scl_o = 1'b1;
  endtask
  task automatic wr(input logic [7:0] d, output logic ack);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(d[i], s);
    bit_io(1'b1, ack);
  endtask
  task automatic rd(input logic last, output logic [7:0] d);
    logic s;
    for (int i = 7; i >= 0; i--)
      bit_io(1'b1, d[i]);
    bit_io(last, s);
  endtask
endmodule
`default_nettype wire

// *** tb.sv ***
// Self-checking bench of smbus_client with a register array model.
// Assumes the host model and the checker are compiled alongside.
`default_nettype none
`define CHECK_EQ(nm, ex, got) \
  begin \
    total_checks++; \
    if ((got) !== (ex)) \
    begin \
      n_errors++; \
      $display("CHECK FAILED %s exp %h got %h", nm, ex, got); \
    end \
  end
module tb;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int TO = 200;
  logic        clk_i = 1'b0;
  logic        rst_i = 1'b1;
  logic        ten = 1'b0;
  logic        slp = 1'b0;
  logic        scl, sda_low, oe, dout, we, rd, awake, busy, a;
  logic [7:0]  raddr, wdata, eptr, d;
  logic [7:0]  mem [256];
  logic [7:0]  emem [256];
  logic [7:0]  bad [3] = '{8'h52, 8'hd0, 8'h53};
  logic [31:0] seed = 32'h23ee;
  int          n_errors = 0;
  int          total_checks = 0;
  int          n_rd = 0;
  wire logic   sda;
  assign sda = !(sda_low || (oe && !dout));
  always #25 clk_i = !clk_i;
  always @(posedge clk_i)
    if (we)
      mem[raddr] <= wdata;
  // Every byte sent to the host must be fetched by exactly one read strobe.
  always @(posedge clk_i)
    if (rd)
      n_rd <= n_rd + 1;
  smbus_client #(.TIMEOUT_CYCLES(TO)) u_dut
  (
    .clk_i(clk_i), .rst_i(rst_i), .bus_clock_pin_i(scl),
    .bus_data_pin_i(sda), .bus_data_pin_o(dout), .bus_data_pin_oe_o(oe),
    .timeout_en_i(ten), .lowest_power_sleep_bit_i(slp),
    .reg_addr_o(raddr), .reg_wdata_o(wdata), .reg_we_o(we),
    .reg_rd_o(rd), .reg_rdata_i(mem[raddr]), .awake_o(awake), .busy_o(busy)
  );
  smbus_host_model u_host
  (
    .sda_i(sda), .scl_o(scl), .sda_low_o(sda_low)
  );
  function automatic logic [31:0] rnd();
    seed ^= seed << 13;
    seed ^= seed >> 17;
    seed ^= seed << 5;
    return seed;
  endfunction
  function automatic logic [7:0] nxt(input logic [7:0] p);
    return p + 8'h01;
  endfunction
  task automatic cfg(input logic t, input logic s);
    @(posedge clk_i);
    ten <= t;
    slp <= s;
    #13;
  endtask
  task automatic wr_xfer(input logic [7:0] p, input int n);
    u_host.start();
    u_host.wr(8'h50, a);
    `CHECK_EQ("addr ack", 1'b0, a)
    u_host.wr(p, a);
    `CHECK_EQ("ptr ack", 1'b0, a)
    eptr = p;
    for (int i = 0; i < n; i++)
    begin
      d = 8'(rnd());
      u_host.wr(d, a);
      `CHECK_EQ("data ack", 1'b0, a)
      emem[eptr] = d;
      eptr = nxt(eptr);
    end
    u_host.stop();
  endtask
  task automatic rd_xfer(input logic set, input logic [7:0] p, input int n);
    int rd0;
    rd0 = n_rd;
    u_host.start();
    if (set)
    begin
      u_host.wr(8'h50, a);
      u_host.wr(p, a);
      eptr = p;
      u_host.start();
    end
    u_host.wr(8'h51, a);
    `CHECK_EQ("rd addr ack", 1'b0, a)
    for (int i = 0; i < n; i++)
    begin
      u_host.rd(i == n - 1, d);
      `CHECK_EQ("rd data", emem[eptr], d)
      eptr = nxt(eptr);
    end
    u_host.stop();
    `CHECK_EQ("rd strobes", rd0 + n, n_rd)
  endtask
  task automatic report_and_stop();
    $display("checks %0d errors %0d", total_checks, n_errors);
    if (n_errors == 0 && total_checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask
  initial
  begin
    #4_000_000;
    n_errors++;
    report_and_stop();
  end
  initial
  begin
    for (int i = 0; i < 256; i++)
    begin
      mem[i] = 8'(rnd());
      emem[i] = mem[i];
    end
    repeat (8) @(posedge clk_i);
    rst_i <= 1'b0;
    repeat (5) @(posedge clk_i);
    #13;
    wr_xfer(8'hfe, 4);
    rd_xfer(1'b1, 8'hfd, 5);
    rd_xfer(1'b0, 8'h00, 2);
    wr_xfer(8'h40, 0);
    rd_xfer(1'b0, 8'h00, 1);
    for (int k = 0; k < 4; k++)
    begin
      u_host.stretch = 300 + 100 * (rnd() % 3);
      wr_xfer(8'(rnd()), int'(1 + rnd() % 3));
      rd_xfer(1'b1, 8'(rnd()), int'(1 + rnd() % 4));
    end
    for (int k = 0; k < 3; k++)
    begin
      u_host.start();
      u_host.wr(bad[k], a);
      `CHECK_EQ("bad addr", 1'b1, a)
      u_host.wr(8'h00, a);
      `CHECK_EQ("ignored", 1'b1, a)
      u_host.stop();
    end
    rd_xfer(1'b0, 8'h00, 1);
    cfg(1'b0, 1'b1);
    u_host.start();
    u_host.wr(8'h50, a);
    `CHECK_EQ("awake", 1'b1, awake)
    u_host.wr(8'h10, a);
    u_host.stop();
    #500;
    `CHECK_EQ("asleep", 1'b0, awake)
    cfg(1'b0, 1'b0);
    u_host.start();
    u_host.wr(8'h50, a);
    #(TO * 100);
    `CHECK_EQ("no timeout", 1'b1, busy)
    u_host.stop();
    cfg(1'b1, 1'b0);
    u_host.start();
    u_host.wr(8'h50, a);
    #(TO * 50 + 2000);
    `CHECK_EQ("low timeout", 1'b0, busy)
    u_host.start();
    u_host.wr(8'h50, a);
    u_host.release_bus();
    #210000;
    `CHECK_EQ("idle reset", 1'b0, busy)
    u_host.stop();
    cfg(1'b0, 1'b0);
    rd_xfer(1'b1, 8'h20, 2);
    for (int i = 0; i < 256; i++)
      `CHECK_EQ("reg array", emem[i], mem[i])
    report_and_stop();
  end
endmodule
bind smbus_client smbus_client_assertions
  #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_chk
(
  .clk_i(clk_i), .rst_i(rst_i), .bus_clock_pin_i(bus_clock_pin_i),
  .bus_data_pin_i(bus_data_pin_i), .bus_data_pin_oe_o(bus_data_pin_oe_o),
  .timeout_en_i(timeout_en_i),
  .lowest_power_sleep_bit_i(lowest_power_sleep_bit_i),
  .reg_addr_o(reg_addr_o), .reg_we_o(reg_we_o), .awake_o(awake_o),
  .busy_o(busy_o)
);
`default_nettype wire
